// File: sim/alp_pins.sv
`timescale 1ns/10ps
// Pin model: external drivers, weak pull-ups, floating lines
module alp_pins
   import alp_pkg::*;
(
   input wire logic clk_i,
   input wire logic [PA_W-1:0] pa_out_i,
   input wire logic [PA_W-1:0] pa_oe_i,
   input wire logic [PA_W-1:0] ext_pa_i,
   input wire logic [PC_W-1:0] pc_out_i,
   input wire logic [PC_W-1:0] pc_oe_i,
   input wire logic [PU_W-1:0] pc_pullup_i,
   input wire logic [PC_W-1:0] ext_pc_i,
   input wire logic [PC_W-1:0] ext_en_i,
   output logic [PA_W-1:0] pa_in_o,
   output logic [PC_W-1:0] pc_in_o
);
   logic [PC_W-1:0] last_r = '0;
   logic [PC_W-1:0] pu;

   assign pu = {2'b00, pc_pullup_i};

   // Analog port: device drive wins over the outside source
   always_comb begin
      for (int i = 0; i < PA_W; i++) begin
         pa_in_o[i] = pa_oe_i[i] ? pa_out_i[i] : ext_pa_i[i];
      end
   end

   // Device drive, then outside drive, then pull-up, else drifting
   always_comb begin
      for (int i = 0; i < PC_W; i++) begin
         if (pc_oe_i[i]) begin
            pc_in_o[i] = pc_out_i[i];
         end else if (ext_en_i[i]) begin
            pc_in_o[i] = ext_pc_i[i];
         end else if (pu[i]) begin
            pc_in_o[i] = 1'b1;
         end else begin
            pc_in_o[i] = ~last_r[i];
         end
      end
   end

   // Last level, so a released line never holds its value
   always @(posedge clk_i) begin
      last_r <= pc_in_o;
   end
endmodule

// File: sim/alp_port_pair_tb_top.sv
`timescale 1ns/10ps
module alp_port_pair_tb_top;
   import alp_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   alp_wb_req_t wb_i = '0;
   alp_wb_rsp_t wb_o;
   logic [PA_W-1:0] pa_in, pa_out, pa_oe, pa_ana;
   logic [PA_W-1:0] ext_pa = '0;
   logic [PC_W-1:0] pc_in, pc_out, pc_oe;
   logic [PC_W-1:0] ext_pc = '0;
   logic [PC_W-1:0] ext_en = '1;
   logic [PU_W-1:0] pu;
   logic hib = 1'b0, ref_a = 1'b0, cmp_a = 1'b0, prog = 1'b0;
   logic sda_o = 1'b0, sda_oe = 1'b0, scl_o = 1'b0, scl_oe = 1'b0;
   logic sda_pin, scl_pin, ser_en, tck, comp_a_output_enable, flag, wake;
   int mismatches = 0;
   int total_checks = 0;

   // 50 MHz clock
   always #10 clk_i = ~clk_i;

   alp_port_pair DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
      .wb_o(wb_o), .pa_in_i(pa_in), .pa_out_o(pa_out), .pa_oe_o(pa_oe),
      .pa_analog_o(pa_ana), .pc_in_i(pc_in), .pc_out_o(pc_out),
      .pc_oe_o(pc_oe), .pc_pullup_o(pu), .hibernate_i(hib),
      .ref_a_i(ref_a), .cmp_a_i(cmp_a), .ser_sda_out_i(sda_o),
      .ser_sda_oe_i(sda_oe), .ser_scl_out_i(scl_o), .ser_scl_oe_i(scl_oe),
      .prog_mode_i(prog), .prog_sda_out_i(1'b1), .prog_sda_oe_i(prog),
      .serial_bus_data_pin_o(sda_pin), .serial_bus_clock_pin_o(scl_pin),
      .serial_bus_en_o(ser_en), .timer_ext_clock_in_o(tck),
      .comp_a_output_enable_o(comp_a_output_enable), .change_int_flag_o(flag),
      .wake_o(wake));

   alp_pins pins (.clk_i(clk_i), .pa_out_i(pa_out), .pa_oe_i(pa_oe),
      .ext_pa_i(ext_pa), .pc_out_i(pc_out), .pc_oe_i(pc_oe),
      .pc_pullup_i(pu), .ext_pc_i(ext_pc), .ext_en_i(ext_en),
      .pa_in_o(pa_in), .pc_in_o(pc_in));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // One classic Wishbone cycle, held until ack is sampled
   task automatic acc(input logic w, input logic [IDX_W-1:0] idx,
                      input logic [7:0] d, output logic [7:0] q);
      wb_i.cyc <= 1'b1;
      wb_i.stb <= 1'b1;
      wb_i.we <= w;
      wb_i.adr <= {idx, 2'b00};
      wb_i.sel <= 4'hf;
      wb_i.dat <= {24'h0, d};
      do begin
         @(negedge clk_i);
      end while (wb_o.ack !== 1'b1);
      @(posedge clk_i);
      q = wb_o.dat[7:0];
      wb_i.cyc <= 1'b0;
      wb_i.stb <= 1'b0;
      wb_i.we <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
      logic [7:0] q;
      acc(1'b1, idx, d, q);
   endtask

   task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [7:0] e);
      logic [7:0] q;
      acc(1'b0, idx, 8'h00, q);
      chk(q, e);
   endtask

   task automatic t_reset();
      chk({4'h0, pa_ana}, 8'h0f);
      chk({4'h0, pa_oe}, 8'h00);
      chk(pc_oe, 8'h00);
      chk({2'b00, pu}, 8'h00);
      rd_chk(IDX_PA_DIR, 8'h0f);
      rd_chk(IDX_PC_DIR, 8'hff);
      rd_chk(10'h3ff, 8'h00);
   endtask

   task automatic t_analog();
      logic [3:0] m [4] = '{4'hf, 4'h7, 4'h3, 4'h0};
      ext_pa <= 4'hf;
      for (int i = 0; i < 4; i++) begin
         wr(IDX_CONV_CFG, 8'(i));
         chk({4'h0, pa_ana}, {4'h0, m[i]});
         rd_chk(IDX_PA_DATA, {4'h0, ~m[i]});
      end
      ext_pa <= 4'ha;
      rd_chk(IDX_PA_DATA, 8'h0a);
      wr(IDX_PA_DATA, 8'hf5);
      chk({4'h0, pa_out}, 8'h05);
      chk({4'h0, pa_oe}, 8'h00);
      wr(IDX_PA_DIR, 8'h0c);
      chk({4'h0, pa_oe}, 8'h03);
      rd_chk(IDX_PA_DATA, 8'h09);
      wr(IDX_CONV_CFG, 8'h00);
      chk({4'h0, pa_oe}, 8'h03);
      wr(IDX_PA_DIR, 8'h0f);
   endtask

   task automatic t_pullup();
      wr(IDX_OPTION, 8'h00);
      chk({2'b00, pu}, 8'h3f);
      wr(IDX_PC_DIR, 8'hfa);
      chk({2'b00, pu}, 8'h3a);
      hib <= 1'b1;
      step(1);
      chk({2'b00, pu}, 8'h00);
      hib <= 1'b0;
      wr(IDX_OPTION, 8'h80);
      chk({2'b00, pu}, 8'h00);
      wr(IDX_PC_DIR, 8'hff);
   endtask

   task automatic t_led();
      wr(IDX_PC_DATA, 8'ha5);
      wr(IDX_PC_DIR, 8'h00);
      chk(pc_out, 8'ha5);
      chk(pc_oe, 8'hff);
      rd_chk(IDX_PC_DATA, 8'ha5);
      rd_chk(IDX_PC_DIR, 8'h00);
   endtask

   task automatic t_change();
      wr(IDX_PC_DIR, 8'hff);
      rd_chk(IDX_PC_DATA, 8'h00);
      wr(IDX_INT_FLAGS, 8'h00);
      chk({7'h0, flag}, 8'h00);
      ext_pc <= 8'h08;
      step(2);
      chk({7'h0, flag}, 8'h00);
      ext_pc <= 8'h18;
      step(2);
      chk({7'h0, flag}, 8'h01);
      chk({7'h0, wake}, 8'h00);
      wr(IDX_INT_ENABLES, 8'h04);
      chk({7'h0, wake}, 8'h01);
      wr(IDX_INT_FLAGS, 8'h00);
      chk({7'h0, flag}, 8'h01);
      rd_chk(IDX_PC_DATA, 8'h18);
      wr(IDX_INT_FLAGS, 8'h00);
      chk({7'h0, flag}, 8'h00);
      wr(IDX_SER_CTRL, 8'h20);
      chk({7'h0, ser_en}, 8'h01);
      ext_pc <= 8'hd8;
      step(2);
      chk({7'h0, flag}, 8'h00);
      wr(IDX_PC_DIR, 8'hcf);
      step(2);
      chk({7'h0, flag}, 8'h00);
      wr(IDX_SER_CTRL, 8'h00);
      step(2);
      chk({7'h0, flag}, 8'h01);
      wr(IDX_PC_DIR, 8'hff);
      rd_chk(IDX_PC_DATA, 8'hd8);
      wr(IDX_INT_FLAGS, 8'h00);
      wr(IDX_INT_ENABLES, 8'h00);
   endtask

   task automatic t_override();
      ref_a <= 1'b1;
      wr(IDX_PC_DATA, 8'h02);
      wr(IDX_PC_DIR, 8'hfe);
      wr(IDX_CMP_CTRL, 8'h02);
      chk({7'h0, comp_a_output_enable}, 8'h01);
      chk({6'h0, pc_oe[1:0]}, 8'h03);
      chk({6'h0, pc_out[1:0]}, 8'h01);
      ext_pc <= 8'h48;
      step(1);
      chk({7'h0, tck}, 8'h01);
      chk({7'h0, scl_pin}, 8'h01);
      ext_pc <= 8'h00;
      step(1);
      chk({7'h0, tck}, 8'h00);
      wr(IDX_SER_CTRL, 8'h20);
      sda_oe <= 1'b1;
      step(1);
      chk({7'h0, pc_oe[7]}, 8'h01);
      chk({7'h0, sda_pin}, 8'h00);
      prog <= 1'b1;
      step(1);
      chk({6'h0, pc_oe[7:6]}, 8'h02);
      chk({7'h0, sda_pin}, 8'h01);
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Watchdog: the whole sequence needs well under 2000 cycles
   initial begin
      #100000;
      mismatches++;
      results();
   end

   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_analog();
      t_pullup();
      t_led();
      t_change();
      t_override();
      results();
   end
endmodule

// File: src/alp_chg_det.sv
`timescale 1ns/10ps
module alp_chg_det
   import alp_pkg::*;
#(
   parameter int N = CHG_W
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [N-1:0] pins_i,
   input wire logic [N-1:0] dir_i,
   input wire logic excl_top_i,
   input wire logic capture_i,
   output logic mismatch_o,
   output logic [N-1:0] latch_o
);

   typedef struct packed {
      logic [N-1:0] latch;
   } alp_chg_state_t;

   alp_chg_state_t s_r;
   alp_chg_state_t s_nxt;
   logic [N-1:0] part;

   // Every port read reloads the comparison latch
   always_comb begin
      s_nxt = s_r;
      if (capture_i) begin
         s_nxt.latch = pins_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Inputs only, top two dropped while the serial bus owns them
   assign part = dir_i & (excl_top_i ? {2'b00, {(N-2){1'b1}}} : '1);
   assign mismatch_o = |((pins_i ^ s_r.latch) & part);
   assign latch_o = s_r.latch;

endmodule

// File: src/alp_pkg.sv
package alp_pkg;

   // Register index width; byte address is four times the index
   localparam int IDX_W = 10;
   localparam int ADR_W = 12;
   localparam int IDX_LSB = 2;

   // Register indices
   localparam logic [IDX_W-1:0] IDX_PA_DATA = 10'h005;
   localparam logic [IDX_W-1:0] IDX_PA_DIR = 10'h085;
   localparam logic [IDX_W-1:0] IDX_PC_DATA = 10'h007;
   localparam logic [IDX_W-1:0] IDX_PC_DIR = 10'h087;
   localparam logic [IDX_W-1:0] IDX_OPTION = 10'h081;
   localparam logic [IDX_W-1:0] IDX_INT_FLAGS = 10'h00c;
   localparam logic [IDX_W-1:0] IDX_INT_ENABLES = 10'h08c;
   localparam logic [IDX_W-1:0] IDX_CMP_CTRL = 10'h01f;
   localparam logic [IDX_W-1:0] IDX_SER_CTRL = 10'h014;
   localparam logic [IDX_W-1:0] IDX_CONV_CFG = 10'h09f;

   // Port widths
   localparam int PA_W = 4;
   localparam int PC_W = 8;
   localparam int PU_W = 6;
   localparam int CHG_W = 4;

   // Field positions
   localparam int PU_DIS_BIT = 7;
   localparam int CHG_BIT = 2;
   localparam int COMP_A_OUTPUT_ENABLE_BIT = 1;
   localparam int SER_EN_BIT = 5;
   localparam int PIN_REF = 0;
   localparam int PIN_CMP = 1;
   localparam int PIN_TCK = 3;
   localparam int CHG_LO = 4;
   localparam int PIN_SCL = 6;
   localparam int PIN_SDA = 7;

   // Reset values
   localparam logic [PA_W-1:0] PA_DIR_RST = 4'hf;
   localparam logic [PC_W-1:0] PC_DIR_RST = 8'hff;
   localparam logic [1:0] CONV_CFG_RST = 2'h0;
   localparam logic PU_DIS_N_RST = 1'b1;

   // Analog pin masks per converter configuration code
   localparam logic [PA_W-1:0] ANA_MASK_0 = 4'hf;
   localparam logic [PA_W-1:0] ANA_MASK_1 = 4'h7;
   localparam logic [PA_W-1:0] ANA_MASK_2 = 4'h3;
   localparam logic [PA_W-1:0] ANA_MASK_3 = 4'h0;

   // Wishbone request and answer
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [ADR_W-1:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } alp_wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } alp_wb_rsp_t;

   // Decoded register access
   typedef struct packed {
      logic rd;
      logic wr;
      logic [IDX_W-1:0] idx;
      logic [7:0] wdata;
   } alp_cmd_t;

   // Which analog port pins are analog
   function automatic logic [PA_W-1:0] alp_ana_mask(input logic [1:0] cfg);
      unique case (cfg)
         2'h0: alp_ana_mask = ANA_MASK_0;
         2'h1: alp_ana_mask = ANA_MASK_1;
         2'h2: alp_ana_mask = ANA_MASK_2;
         2'h3: alp_ana_mask = ANA_MASK_3;
      endcase
   endfunction

endpackage

// File: src/alp_port_pair.sv
`timescale 1ns/10ps
// Behaviour
// - Reset puts all analog port pins analog
// - Analog direction bit 1 means input, always
// - Analog direction register resets to all ones
// - Digital input gated off in analog mode
// - Analog data upper four bits read zero
// - Analog data read: pin or zero
// - LED port data and direction decoded
// - Clearing pull-up disable enables six pull-ups
// - Pull-up off for outputs, reset, hibernate
// - Only upper four input pins detect change
// - Mismatch with read latch sets flag
// - Serial bus enable excludes top two pins
// - Pending enabled change wakes from sleep
// - Persistent mismatch keeps setting the flag
// - Comparator enable overrides pins zero, one
// - Top pins carry serial bus and programming
// - LED direction register resets to all ones
// - Pin three feeds timer external clock
// - Converter config selects analog pins
// - Digital read pins, write latch only
module alp_port_pair
   import alp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire alp_wb_req_t wb_i,
   output alp_wb_rsp_t wb_o,
   input wire logic [PA_W-1:0] pa_in_i,
   output logic [PA_W-1:0] pa_out_o,
   output logic [PA_W-1:0] pa_oe_o,
   output logic [PA_W-1:0] pa_analog_o,
   input wire logic [PC_W-1:0] pc_in_i,
   output logic [PC_W-1:0] pc_out_o,
   output logic [PC_W-1:0] pc_oe_o,
   output logic [PU_W-1:0] pc_pullup_o,
   input wire logic hibernate_i,
   input wire logic ref_a_i,
   input wire logic cmp_a_i,
   input wire logic ser_sda_out_i,
   input wire logic ser_sda_oe_i,
   input wire logic ser_scl_out_i,
   input wire logic ser_scl_oe_i,
   input wire logic prog_mode_i,
   input wire logic prog_sda_out_i,
   input wire logic prog_sda_oe_i,
   output logic serial_bus_data_pin_o,
   output logic serial_bus_clock_pin_o,
   output logic serial_bus_en_o,
   output logic timer_ext_clock_in_o,
   output logic comp_a_output_enable_o,
   output logic change_int_flag_o,
   output logic wake_o
);

   typedef struct packed {
      logic [PA_W-1:0] pa_lat;
      logic [PA_W-1:0] pa_dir;
      logic [PC_W-1:0] pc_lat;
      logic [PC_W-1:0] pc_dir;
      logic pu_dis_n;
      logic chg_flag;
      logic chg_en;
      logic comp_a_output_enable;
      logic ser_en;
      logic [1:0] conv_cfg;
      logic [7:0] rdata;
   } alp_state_t;

   alp_state_t s_r;
   alp_state_t s_nxt;
   alp_cmd_t cmd;
   logic ack;
   logic mismatch;
   logic [CHG_W-1:0] chg_latch;
   logic [PA_W-1:0] ana_mask;
   logic [PA_W-1:0] pa_din;
   logic [7:0] rd_val;
   logic [PC_W-1:0] eff_oe;
   logic pc_rd;

   // Bus slave
   alp_wb_slave u_wbs (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .req_i(wb_i),
      .ack_o(ack),
      .cmd_o(cmd)
   );

   // Change detection on the upper four LED port pins
   assign pc_rd = cmd.rd & (cmd.idx == IDX_PC_DATA);

   alp_chg_det #(
      .N(CHG_W)
   ) u_chg (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pins_i(pc_in_i[PC_W-1:CHG_LO]),
      .dir_i(s_r.pc_dir[PC_W-1:CHG_LO]),
      .excl_top_i(s_r.ser_en),
      .capture_i(pc_rd),
      .mismatch_o(mismatch),
      .latch_o(chg_latch)
   );

   // Analog gating of the digital input path
   assign ana_mask = alp_ana_mask(s_r.conv_cfg);
   assign pa_din = pa_in_i & ~ana_mask;

   // Read mux; unmapped and unimplemented bits read zero
   always_comb begin
      rd_val = 8'h00;
      unique case (cmd.idx)
         IDX_PA_DATA: rd_val = {4'h0, pa_din};
         IDX_PA_DIR: rd_val = {4'h0, s_r.pa_dir};
         IDX_PC_DATA: rd_val = pc_in_i;
         IDX_PC_DIR: rd_val = s_r.pc_dir;
         IDX_OPTION: rd_val[PU_DIS_BIT] = s_r.pu_dis_n;
         IDX_INT_FLAGS: rd_val[CHG_BIT] = s_r.chg_flag;
         IDX_INT_ENABLES: rd_val[CHG_BIT] = s_r.chg_en;
         IDX_CMP_CTRL: rd_val[COMP_A_OUTPUT_ENABLE_BIT] = s_r.comp_a_output_enable;
         IDX_SER_CTRL: rd_val[SER_EN_BIT] = s_r.ser_en;
         IDX_CONV_CFG: rd_val[1:0] = s_r.conv_cfg;
         default: rd_val = 8'h00;
      endcase
   end

   // Register writes, read data capture and change flag
   always_comb begin
      s_nxt = s_r;
      if (cmd.rd) begin
         s_nxt.rdata = rd_val;
      end
      if (cmd.wr) begin
         unique case (cmd.idx)
            IDX_PA_DATA: s_nxt.pa_lat = cmd.wdata[PA_W-1:0];
            IDX_PA_DIR: s_nxt.pa_dir = cmd.wdata[PA_W-1:0];
            IDX_PC_DATA: s_nxt.pc_lat = cmd.wdata;
            IDX_PC_DIR: s_nxt.pc_dir = cmd.wdata;
            IDX_OPTION: s_nxt.pu_dis_n = cmd.wdata[PU_DIS_BIT];
            IDX_INT_FLAGS: s_nxt.chg_flag = cmd.wdata[CHG_BIT];
            IDX_INT_ENABLES: s_nxt.chg_en = cmd.wdata[CHG_BIT];
            IDX_CMP_CTRL: s_nxt.comp_a_output_enable = cmd.wdata[COMP_A_OUTPUT_ENABLE_BIT];
            IDX_SER_CTRL: s_nxt.ser_en = cmd.wdata[SER_EN_BIT];
            IDX_CONV_CFG: s_nxt.conv_cfg = cmd.wdata[1:0];
            default: s_nxt = s_nxt;
         endcase
      end
      // Mismatch sets every cycle and beats a software clear
      if (mismatch) begin
         s_nxt.chg_flag = 1'b1;
      end
   end

   // State register and reset values
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
         s_r.pa_dir <= PA_DIR_RST;
         s_r.pc_dir <= PC_DIR_RST;
         s_r.conv_cfg <= CONV_CFG_RST;
         s_r.pu_dis_n <= PU_DIS_N_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Bus answer
   assign wb_o.ack = ack;
   assign wb_o.dat = {24'h000000, s_r.rdata};

   // Analog port pins; direction holds even in analog mode
   assign pa_out_o = s_r.pa_lat;
   assign pa_oe_o = ~s_r.pa_dir;
   assign pa_analog_o = ana_mask;

   // LED port drivers with comparator and serial bus overrides
   always_comb begin
      pc_out_o = s_r.pc_lat;
      eff_oe = ~s_r.pc_dir;
      if (s_r.comp_a_output_enable) begin
         pc_out_o[PIN_REF] = ref_a_i;
         pc_out_o[PIN_CMP] = cmp_a_i;
         eff_oe[PIN_REF] = 1'b1;
         eff_oe[PIN_CMP] = 1'b1;
      end
      if (prog_mode_i) begin
         pc_out_o[PIN_SDA] = prog_sda_out_i;
         eff_oe[PIN_SDA] = prog_sda_oe_i;
         pc_out_o[PIN_SCL] = 1'b0;
         eff_oe[PIN_SCL] = 1'b0;
      end else if (s_r.ser_en) begin
         pc_out_o[PIN_SDA] = ser_sda_out_i;
         eff_oe[PIN_SDA] = ser_sda_oe_i;
         pc_out_o[PIN_SCL] = ser_scl_out_i;
         eff_oe[PIN_SCL] = ser_scl_oe_i;
      end
   end

   assign pc_oe_o = eff_oe;

   // Weak pull-ups: common enable, off for outputs and hibernate
   assign pc_pullup_o = {PU_W{~s_r.pu_dis_n & ~hibernate_i}} &
                        s_r.pc_dir[PU_W-1:0] &
                        ~eff_oe[PU_W-1:0];

   // Pin levels handed to other blocks
   assign serial_bus_data_pin_o = pc_in_i[PIN_SDA];
   assign serial_bus_clock_pin_o = pc_in_i[PIN_SCL];
   assign timer_ext_clock_in_o = pc_in_i[PIN_TCK];
   assign serial_bus_en_o = s_r.ser_en;
   assign comp_a_output_enable_o = s_r.comp_a_output_enable;
   assign change_int_flag_o = s_r.chg_flag;
   assign wake_o = s_r.chg_flag & s_r.chg_en;

   // Checks
   sequence s_pa_read;
      cmd.rd && cmd.idx == IDX_PA_DATA;
   endsequence

   sequence s_pc_read;
      cmd.rd && cmd.idx == IDX_PC_DATA;
   endsequence

   property p_reset_analog;
      @(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> pa_analog_o == 4'hf;
   endproperty
   a_reset_analog: assert property (p_reset_analog)
      else $error("analog port not all analog after reset");

   property p_reset_dirs;
      @(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> pa_oe_o == 4'h0 && pc_oe_o == 8'h00;
   endproperty
   a_reset_dirs: assert property (p_reset_dirs)
      else $error("port pins not inputs after reset");

   property p_pa_dir_write;
      @(posedge clk_i) disable iff (rst_i)
      (cmd.wr && cmd.idx == IDX_PA_DIR) |=> pa_oe_o == ~$past(cmd.wdata[3:0]);
   endproperty
   a_pa_dir_write: assert property (p_pa_dir_write)
      else $error("analog direction write not reflected on enables");

   property p_pa_read;
      @(posedge clk_i) disable iff (rst_i)
      s_pa_read |=> wb_o.dat == {28'h0, $past(pa_in_i) & ~$past(ana_mask)};
   endproperty
   a_pa_read: assert property (p_pa_read)
      else $error("analog port read value wrong");

   property p_pc_read_latch;
      @(posedge clk_i) disable iff (rst_i)
      s_pc_read |=> chg_latch == $past(pc_in_i[7:4]) && wb_o.ack;
   endproperty
   a_pc_read_latch: assert property (p_pc_read_latch)
      else $error("port read did not reload change latch");

   property p_mismatch_flag;
      @(posedge clk_i) disable iff (rst_i)
      mismatch |=> change_int_flag_o;
   endproperty
   a_mismatch_flag: assert property (p_mismatch_flag)
      else $error("mismatch did not set change flag");

   property p_pullup_gate;
      @(posedge clk_i) disable iff (rst_i)
      (|pc_pullup_o) |-> !s_r.pu_dis_n && !hibernate_i &&
         ((pc_pullup_o & ~s_r.pc_dir[5:0]) == 6'h00);
   endproperty
   a_pullup_gate: assert property (p_pullup_gate)
      else $error("pull-up on while disabled or output");

   property p_cmp_override;
      @(posedge clk_i) disable iff (rst_i)
      s_r.comp_a_output_enable |-> pc_oe_o[1:0] == 2'b11 && pc_out_o[1] == cmp_a_i &&
         pc_out_o[0] == ref_a_i;
   endproperty
   a_cmp_override: assert property (p_cmp_override)
      else $error("comparator override not applied");

   property p_pc_data_write;
      @(posedge clk_i) disable iff (rst_i)
      (cmd.wr && cmd.idx == IDX_PC_DATA && !s_r.comp_a_output_enable && !s_r.ser_en &&
         !prog_mode_i) |=> pc_out_o == $past(cmd.wdata) || s_r.comp_a_output_enable ||
         s_r.ser_en || prog_mode_i;
   endproperty
   a_pc_data_write: assert property (p_pc_data_write)
      else $error("LED port data write not on pins");

   property p_wake;
      @(posedge clk_i) disable iff (rst_i)
      (s_r.chg_en && mismatch) |=> wake_o;
   endproperty
   a_wake: assert property (p_wake)
      else $error("pending change did not wake");

   property p_pa_upper_zero;
      @(posedge clk_i) disable iff (rst_i)
      s_pa_read |=> wb_o.dat[7:4] == 4'h0;
   endproperty
   a_pa_upper_zero: assert property (p_pa_upper_zero)
      else $error("analog port upper bits not zero");

   property p_reset_pullup;
      @(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> pc_pullup_o == 6'h00;
   endproperty
   a_reset_pullup: assert property (p_reset_pullup)
      else $error("pull-ups on after reset");

   property p_pullup_on;
      @(posedge clk_i) disable iff (rst_i)
      (!s_r.pu_dis_n && !hibernate_i && !s_r.comp_a_output_enable) |->
         pc_pullup_o == s_r.pc_dir[PU_W-1:0];
   endproperty
   a_pullup_on: assert property (p_pullup_on)
      else $error("pull-ups not on for input pins");

   property p_ser_excl;
      @(posedge clk_i) disable iff (rst_i)
      (s_r.ser_en && pc_in_i[5:4] == chg_latch[1:0]) |-> !mismatch;
   endproperty
   a_ser_excl: assert property (p_ser_excl)
      else $error("serial bus pins not excluded from change");

   property p_pc_read_value;
      @(posedge clk_i) disable iff (rst_i)
      s_pc_read |=> wb_o.dat[7:0] == $past(pc_in_i);
   endproperty
   a_pc_read_value: assert property (p_pc_read_value)
      else $error("LED port read did not return pin levels");

   property p_ser_pins;
      @(posedge clk_i) disable iff (rst_i)
      (s_r.ser_en && !prog_mode_i) |-> pc_oe_o[PIN_SDA] == ser_sda_oe_i &&
         pc_oe_o[PIN_SCL] == ser_scl_oe_i;
   endproperty
   a_ser_pins: assert property (p_ser_pins)
      else $error("serial bus does not own top pins");

endmodule

// File: src/alp_wb_slave.sv
`timescale 1ns/10ps
module alp_wb_slave
   import alp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire alp_wb_req_t req_i,
   output logic ack_o,
   output alp_cmd_t cmd_o
);

   typedef struct packed {
      logic ack;
   } alp_wbs_state_t;

   alp_wbs_state_t s_r;
   alp_wbs_state_t s_nxt;
   logic hit;

   // Ack one cycle after the request, dropped the cycle after
   assign hit = req_i.cyc & req_i.stb;

   always_comb begin
      s_nxt = s_r;
      s_nxt.ack = hit & ~s_r.ack;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Read sampled at request start, write commits at the ack edge
   assign ack_o = s_r.ack;
   assign cmd_o.rd = hit & ~s_r.ack & ~req_i.we;
   assign cmd_o.wr = hit & s_r.ack & req_i.we & req_i.sel[0];
   assign cmd_o.idx = req_i.adr[ADR_W-1:IDX_LSB];
   assign cmd_o.wdata = req_i.dat[7:0];

endmodule
